// File: hdl/serdes_cfg_consts.svh
// Constants for the channel serdes configuration register bank
`ifndef SERDES_CFG_CONSTS_SVH
`define SERDES_CFG_CONSTS_SVH
`define DEVAD_VS    5'h1E
`define REG_CTRL    16'h0001
`define REG_PLL     16'h0002
`define CTRL_RESET  16'h0B00
`define CTRL_WMASK  16'hFF03
`define PLL_RESET   16'h831D
`define B_SLEEP     15
`define B_RX11      13
`define B_TX11      12
`define B_PCS       11
`define B_SOFT      10
`define B_SPLIT     9
`define B_MERGE     8
`define B_HSREF     1
`define B_LSALT     0
`define F_BW        9:8
`define B_VCO       6
`define B_PLLON     4
`define F_FACT      3:0
`define PRE_ONES    6'h20
`define HDR_LAST    4'hB
`define DATA_LAST   4'hF
`define OP45_ADDR   2'h0
`define OP45_WR     2'h1
`define OP45_RDINC  2'h2
`define OP22_WR     2'h1
`define OP22_RD     2'h2
// Multiplier times four per code, code 0 in the low byte; zero marks reserved
`define PLL_X4_TABLE 128'h00_64_50_42_40_3C_32_30_28_21_20_18_14_10_00_00
`endif

// File: hdl/serdes_cfg_pkg.sv
// Types shared by the channel serdes configuration modules
package serdes_cfg_pkg;
  typedef enum logic [1:0] {BW_MEDIUM, BW_LOW, BW_HIGH, BW_ULTRA} pll_bw_e;
  typedef enum logic [1:0] {RATIO_1, RATIO_2, RATIO_4} lane_ratio_e;
  typedef enum logic [2:0] {ST_PRE, ST_CLAUSE, ST_HDR, ST_TA, ST_DATA} mdio_state_e;
endpackage

// File: hdl/mgmt_reg_if.sv
// Register access path between the management frame engine and the bank
`timescale 1ns/1ps
interface mgmt_reg_if;
  logic        wr_en;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport frame (output wr_en, addr, wdata, input rdata);
  modport bank  (input wr_en, addr, wdata, output rdata);
endinterface

// File: hdl/pll_factor_decode.sv
// Decode of the high-side PLL multiplier code into a factor times four
`timescale 1ns/1ps
`include "serdes_cfg_consts.svh"
module pll_factor_decode (
  input  wire logic [3:0] code_in,
  output logic      [7:0] factor_x4_out,
  output logic            reserved_out
);
  import serdes_cfg_pkg::*;

  // Quarter steps keep 8.25x and 16.5x exact
  function automatic logic [7:0] factor_x4(input logic [3:0] code);
    logic [127:0] table_bits;
    table_bits = `PLL_X4_TABLE;
    factor_x4 = table_bits[{code, 3'h0} +: 8];
  endfunction

  // Reserved codes carry a zero entry
  assign factor_x4_out = factor_x4(code_in);       // [R12]
  assign reserved_out  = (factor_x4_out == 8'h00); // [R12]
endmodule

// File: hdl/mdio_frame_slave.sv
// Management frame engine for Clause 22 and Clause 45 frames
`timescale 1ns/1ps
`include "serdes_cfg_consts.svh"
module mdio_frame_slave (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       mdc_in,
  input  wire logic       mdio_in,
  input  wire logic [4:0] port_addr_in,
  output logic            mdio_out,
  output logic            mdio_oe_out,
  mgmt_reg_if.frame       reg_port
);
  import serdes_cfg_pkg::*;

  logic [1:0]  mdc_sync;
  logic [1:0]  dat_sync;
  logic [4:0]  pa_s1;
  logic [4:0]  pa_s2;
  logic        mdc_prev;
  mdio_state_e state;
  logic [5:0]  ones;
  logic [3:0]  cnt;
  logic [11:0] hdr;
  logic [15:0] shreg;
  logic        c45;
  logic        match;

  // Decode of the bit stream and the header fields
  wire         mdc_rise  = mdc_sync[1] & ~mdc_prev;
  wire         bit_in    = dat_sync[1];
  wire  [11:0] hdr_next  = {hdr[10:0], bit_in};
  wire  [1:0]  op        = hdr[11:10];
  wire         hdr_match = (hdr_next[9:5] == pa_s2) && (!c45 || hdr_next[4:0] == `DEVAD_VS);
  wire         is_read   = c45 ? op[1] : (op == `OP22_RD);
  wire         is_write  = c45 ? (op == `OP45_WR) : (op == `OP22_WR);
  wire  [15:0] data_in   = {shreg[14:0], bit_in};
  wire         frame_end = mdc_rise && state == ST_DATA && cnt == `DATA_LAST;

  // Pins cross two flops; MDC is slow, so edges are seen a few clocks late
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
    begin
      mdc_sync <= 2'h0;
      dat_sync <= 2'h3;
      pa_s1    <= 5'h00;
      pa_s2    <= 5'h00;
      mdc_prev <= 1'b0;
    end
    else
    begin
      mdc_sync <= {mdc_sync[0], mdc_in};
      dat_sync <= {dat_sync[0], mdio_in};
      pa_s1    <= port_addr_in;
      pa_s2    <= pa_s1;
      mdc_prev <= mdc_sync[1];
    end

  // Write strobe lasts one clock after the last data bit
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
      reg_port.wr_en <= 1'b0;
    else
      reg_port.wr_en <= frame_end && match && is_write;

  // Frame sequencer; a frame for another port or device is ignored whole
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
    begin
      state          <= ST_PRE;
      ones           <= 6'h00;
      cnt            <= 4'h0;
      hdr            <= 12'h000;
      shreg          <= 16'h0000;
      c45            <= 1'b0;
      match          <= 1'b0;
      mdio_out       <= 1'b1;
      mdio_oe_out    <= 1'b0;
      reg_port.addr  <= 16'h0000;
      reg_port.wdata <= 16'h0000;
    end
    else if (mdc_rise)
      unique case (state)
        ST_PRE:
        begin
          ones <= !bit_in ? 6'h00 : (ones == `PRE_ONES) ? ones : ones + 6'h01;
          if (!bit_in && ones == `PRE_ONES)
            state <= ST_CLAUSE;
        end
        ST_CLAUSE:
        begin
          c45   <= ~bit_in;
          cnt   <= 4'h0;
          state <= ST_HDR;
        end
        ST_HDR:
        begin
          hdr <= hdr_next;
          cnt <= cnt + 4'h1;
          if (cnt == `HDR_LAST)
          begin
            state <= ST_TA;
            cnt   <= 4'h0;
            match <= hdr_match;
            if (hdr_match && !c45)
              reg_port.addr <= {11'h000, hdr_next[4:0]};
          end
        end
        ST_TA:
        begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'h0)
          begin
            shreg <= reg_port.rdata;
            if (match && is_read)
            begin
              mdio_oe_out <= 1'b1;
              mdio_out    <= 1'b0;
            end
          end
          else
          begin
            state    <= ST_DATA;
            cnt      <= 4'h0;
            mdio_out <= shreg[15];
            shreg    <= data_in;
          end
        end
        ST_DATA:
        begin
          cnt      <= cnt + 4'h1;
          shreg    <= data_in;
          mdio_out <= shreg[15];
          if (cnt == `DATA_LAST)
          begin
            state          <= ST_PRE;
            ones           <= 6'h00;
            mdio_oe_out    <= 1'b0;
            mdio_out       <= 1'b1;
            reg_port.wdata <= data_in;
            if (match && c45 && op == `OP45_ADDR)
              reg_port.addr <= data_in;
            if (match && c45 && op == `OP45_RDINC)
              reg_port.addr <= reg_port.addr + 16'h0001;
          end
        end
        default:
          state <= ST_PRE;
      endcase
endmodule

// File: hdl/channel_serdes_config_regs.sv
// Per-channel mode, lane ratio, reference clock and PLL configuration bank
//
// Summary of operation
// [R1] Clause 45 manual: PCS choice picks KR/KX
// [R2] Soft speed bit forces 10G; else AN/KX
// [R3] Receive split ratio: 0 is 1:2, 1 is 1:4
// [R4] Transmit merge ratio: 0 is 2:1, 1 is 4:1
// [R5] One-to-one bits override the lane ratios
// [R6] High-side reference: input zero or one
// [R7] Low-side reference: same as high or other
// [R8] PLL bandwidth: medium, low, high, ultra
// [R9] VCO band bit: upper or lower range
// [R10] Host sets low band below 2.5 GHz
// [R11] PLL enable gated by sleep pin, bit
// [R12] PLL factor code table, reserved codes flagged
// [R13] Sleep bit stops data path, not management
// [R14] Host keeps reserved fields by read-modify-write
`timescale 1ns/1ps
`include "serdes_cfg_consts.svh"
module channel_serdes_config_regs (
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   mdc_in,
  input  wire logic                   mdio_in,
  input  wire logic [4:0]             port_addr_in,
  input  wire logic                   mode_strap_in,
  input  wire logic                   clause45_strap_in,
  input  wire logic                   autoneg_on_in,
  input  wire logic                   autoneg_10g_in,
  input  wire logic                   channel_sleep_pin_n_in,
  output logic                        mdio_out,
  output logic                        mdio_oe_out,
  output logic                        speed_10g_out,
  output serdes_cfg_pkg::lane_ratio_e rx_ratio_out,
  output serdes_cfg_pkg::lane_ratio_e tx_ratio_out,
  output logic                        hs_ref_sel_out,
  output logic                        ls_ref_sel_out,
  output serdes_cfg_pkg::pll_bw_e     hs_pll_bw_out,
  output logic                        hs_vco_low_band_out,
  output logic                        hs_pll_enable_out,
  output logic [7:0]                  hs_pll_factor_x4_out,
  output logic                        hs_pll_factor_bad_out,
  output logic                        datapath_sleep_out
);
  import serdes_cfg_pkg::*;

  mgmt_reg_if  bus ();
  logic [15:0] ctrl;
  logic [15:0] pll;
  logic [4:0]  strap_s1;
  logic [4:0]  strap_s2;
  logic [7:0]  factor_x4;
  logic        factor_bad;

  // Management frames keep working whatever the sleep state is
  mdio_frame_slave u_mdio (
    .clk_in       (ref_clk_in),
    .reset_in     (reset_in),
    .mdc_in       (mdc_in),
    .mdio_in      (mdio_in),
    .port_addr_in (port_addr_in),
    .mdio_out     (mdio_out),
    .mdio_oe_out  (mdio_oe_out),
    .reg_port     (bus.frame)
  ); // [R13]

  // Multiplier code lookup
  pll_factor_decode u_fact (
    .code_in       (pll[`F_FACT]),
    .factor_x4_out (factor_x4),
    .reserved_out  (factor_bad)
  );

  // Strap and sleep pins come from outside the clock domain
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in)
    begin
      strap_s1 <= 5'h01;
      strap_s2 <= 5'h01;
    end
    else
    begin
      strap_s1 <= {mode_strap_in, clause45_strap_in, autoneg_on_in,
                   autoneg_10g_in, channel_sleep_pin_n_in};
      strap_s2 <= strap_s1;
    end

  // Named views of the synchronised pins
  wire st_mode   = strap_s2[4];
  wire st_c45    = strap_s2[3];
  wire st_an     = strap_s2[2];
  wire st_an_10g = strap_s2[1];
  wire sleep_n   = strap_s2[0];

  // Named fields of the two registers
  wire channel_sleep_bit    = ctrl[`B_SLEEP];
  wire rx_one_to_one        = ctrl[`B_RX11];
  wire tx_one_to_one        = ctrl[`B_TX11];
  wire backplane_pcs_choice = ctrl[`B_PCS];
  wire soft_speed_choice    = ctrl[`B_SOFT];
  wire rx_lane_split_ratio  = ctrl[`B_SPLIT];
  wire tx_lane_merge_ratio  = ctrl[`B_MERGE];
  wire hs_ref_input_choice  = ctrl[`B_HSREF];
  wire low_side_clock_alt   = ctrl[`B_LSALT];
  wire hs_vco_low_band      = pll[`B_VCO];
  wire hs_pll_on            = pll[`B_PLLON];

  // Register decode; unmapped offsets read as zero
  wire ctrl_hit = (bus.addr == `REG_CTRL);
  wire pll_hit  = (bus.addr == `REG_PLL);
  assign bus.rdata = ctrl_hit ? ctrl : pll_hit ? pll : 16'h0000;

  // Control register; bits 7:2 hold zero and read back zero
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in)
      ctrl <= `CTRL_RESET; // [R1] [R3] [R4] [R5]
    else if (bus.wr_en && ctrl_hit)
      ctrl <= bus.wdata & `CTRL_WMASK;

  // PLL register; reserved bits store whatever the host writes back
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in)
      pll <= `PLL_RESET; // [R8] [R9] [R11] [R12]
    else if (bus.wr_en && pll_hit)
      pll <= bus.wdata; // [R14]

  // Device speed: strap high is taken as hardware 10G selection
  wire manual_kr   = backplane_pcs_choice; // [R1]
  wire auto_speed  = st_an ? st_an_10g : manual_kr; // [R1]
  wire soft_speed  = soft_speed_choice ? 1'b1 :
                     st_c45 ? auto_speed : 1'b0; // [R2]
  wire next_speed  = st_mode ? 1'b1 : soft_speed;

  // Lane ratios apply only in 10G; other modes report one-to-one
  wire lane_ratio_e split_ratio = rx_lane_split_ratio ? RATIO_4 : RATIO_2; // [R3]
  wire lane_ratio_e merge_ratio = tx_lane_merge_ratio ? RATIO_4 : RATIO_2; // [R4]
  wire lane_ratio_e next_rx = (!next_speed || rx_one_to_one) ? RATIO_1 : split_ratio; // [R5]
  wire lane_ratio_e next_tx = (!next_speed || tx_one_to_one) ? RATIO_1 : merge_ratio; // [R5]

  // Reference clock routing; the low side follows or swaps the high side
  wire next_hs_ref = hs_ref_input_choice; // [R6]
  wire next_ls_ref = hs_ref_input_choice ^ low_side_clock_alt; // [R7]

  // Sleep from either source stops the data path and the PLL
  wire next_sleep   = channel_sleep_bit | ~sleep_n; // [R13]
  wire next_pll_en  = hs_pll_on & ~next_sleep; // [R11]

  // All outputs are registered so the analog side sees clean levels
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in)
    begin
      speed_10g_out         <= 1'b0;
      rx_ratio_out          <= RATIO_1;
      tx_ratio_out          <= RATIO_1;
      hs_ref_sel_out        <= 1'b0;
      ls_ref_sel_out        <= 1'b0;
      hs_pll_bw_out         <= BW_MEDIUM;
      hs_vco_low_band_out   <= 1'b0;
      hs_pll_enable_out     <= 1'b0;
      hs_pll_factor_x4_out  <= 8'h00;
      hs_pll_factor_bad_out <= 1'b0;
      datapath_sleep_out    <= 1'b1;
    end
    else
    begin
      speed_10g_out         <= next_speed; // [R2]
      rx_ratio_out          <= next_rx;
      tx_ratio_out          <= next_tx;
      hs_ref_sel_out        <= next_hs_ref;
      ls_ref_sel_out        <= next_ls_ref;
      hs_pll_bw_out         <= pll_bw_e'(pll[`F_BW]); // [R8]
      hs_vco_low_band_out   <= hs_vco_low_band; // [R9]
      hs_pll_enable_out     <= next_pll_en;
      hs_pll_factor_x4_out  <= factor_x4; // [R12]
      hs_pll_factor_bad_out <= factor_bad;
      datapath_sleep_out    <= next_sleep;
    end

  // Checks on the decoded configuration
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  pcs_choice_kr_a: assert property ( // [R1]
    (!st_mode && st_c45 && !st_an && !soft_speed_choice)
    |=> speed_10g_out == $past(backplane_pcs_choice))
    else $error("backplane PCS choice not followed");

  soft_speed_force_a: assert property ( // [R2]
    (!st_mode && soft_speed_choice) ##1 (!st_mode && soft_speed_choice)
    |=> speed_10g_out)
    else $error("soft speed choice did not force 10G");

  clause22_kx_a: assert property ( // [R2]
    (!st_mode && !soft_speed_choice && !st_c45) |=> !speed_10g_out)
    else $error("Clause 22 mode not 1G-KX");

  rx_split_ratio_a: assert property ( // [R3]
    (next_speed && !rx_one_to_one)
    |=> rx_ratio_out == ($past(rx_lane_split_ratio) ? RATIO_4 : RATIO_2))
    else $error("receive split ratio wrong");

  tx_merge_ratio_a: assert property ( // [R4]
    (next_speed && !tx_one_to_one)
    |=> tx_ratio_out == ($past(tx_lane_merge_ratio) ? RATIO_4 : RATIO_2))
    else $error("transmit merge ratio wrong");

  one_to_one_a: assert property ( // [R5]
    (next_speed && rx_one_to_one && tx_one_to_one)
    |=> rx_ratio_out == RATIO_1 && tx_ratio_out == RATIO_1)
    else $error("one-to-one override ignored");

  ref_routing_a: assert property ( // [R7]
    ##1 (ls_ref_sel_out == (hs_ref_sel_out ^ $past(low_side_clock_alt))))
    else $error("low-side reference routing wrong");

  hs_ref_sel_a: assert property ( // [R6]
    $rose(hs_ref_input_choice) |=> hs_ref_sel_out)
    else $error("high-side reference choice not applied");

  pll_sleep_gate_a: assert property ( // [R11]
    (!sleep_n || channel_sleep_bit) |=> !hs_pll_enable_out && datapath_sleep_out)
    else $error("PLL left enabled in sleep");

  pll_bw_field_a: assert property ( // [R8]
    (bus.wr_en && pll_hit) |=> ##1 hs_pll_bw_out == pll_bw_e'($past(bus.wdata[9:8], 2)))
    else $error("PLL bandwidth field not applied");

  vco_band_a: assert property ( // [R9]
    ##1 hs_vco_low_band_out == $past(pll[`B_VCO]))
    else $error("VCO band not following register");

  pll_factor_a: assert property ( // [R12]
    (pll[3:0] == 4'hD) |=> hs_pll_factor_x4_out == 8'h50 && !hs_pll_factor_bad_out)
    else $error("PLL factor decode wrong");

  pll_reserved_a: assert property ( // [R12]
    (pll[3:0] == 4'hF || pll[3:1] == 3'h0) |=> hs_pll_factor_bad_out)
    else $error("reserved PLL code not flagged");

  sleep_mgmt_a: assert property ( // [R13]
    (channel_sleep_bit && bus.wr_en && ctrl_hit) |=> ctrl == $past(bus.wdata & `CTRL_WMASK))
    else $error("management writes blocked in sleep");

  cover_ten_g_one_to_one: cover property (speed_10g_out && rx_ratio_out == RATIO_1);
  cover_ctrl_write: cover property (bus.wr_en && ctrl_hit);
  cover_factor_bad: cover property (hs_pll_factor_bad_out);
  cover_sleep_wake: cover property (datapath_sleep_out ##1 !datapath_sleep_out);
endmodule

// File: sim/mdio_host_model.sv
// Behavioural management host that clocks MDIO frames into the device
`timescale 1ns/1ps
`include "serdes_cfg_consts.svh"
module mdio_host_model (
  input  wire logic clk_in,
  input  wire logic mdio_line_in,
  output logic      mdc_out,
  output logic      mdio_drv_out,
  output logic      mdio_oe_out
);
  // MDC rests low outside frames; the line is left to its pull-up
  initial
  begin
    mdc_out      = 1'b0;
    mdio_drv_out = 1'b1;
    mdio_oe_out  = 1'b0;
  end

  // One MDC period: four reference clocks low, then four high
  task automatic bit_cyc(input logic drv, input logic b, output logic smp);
    @(negedge clk_in);
    mdc_out      = 1'b0;
    mdio_oe_out  = drv;
    mdio_drv_out = b;
    repeat (4) @(negedge clk_in);
    smp     = mdio_line_in;  // Device bit has settled by now
    mdc_out = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask

  // Preamble, start, opcode, port, register or device, turnaround, data
  task automatic frame(input logic c22, input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {1'b0, c22, op, pa, ra};
    rd  = 16'h0000;
    repeat (32) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      bit_cyc(1'b1, hdr[i], s);
    if (op[1])
    begin
      // Reads hand the line to the device for turnaround and data
      repeat (2) bit_cyc(1'b0, 1'b1, s);
      for (int i = 15; i >= 0; i--)
      begin
        bit_cyc(1'b0, 1'b1, s);
        rd[i] = s;
      end
    end
    else
    begin
      bit_cyc(1'b1, 1'b1, s);
      bit_cyc(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--)
        bit_cyc(1'b1, wd[i], s);
    end
    @(negedge clk_in);
    mdc_out     = 1'b0;
    mdio_oe_out = 1'b0;
  endtask

  // Clause 45 accesses always set the pointer first
  task automatic wr45(input logic [4:0] pa, input logic [15:0] ad, input logic [15:0] wd);
    logic [15:0] d;
    frame(1'b0, `OP45_ADDR, pa, `DEVAD_VS, ad, d);
    frame(1'b0, `OP45_WR, pa, `DEVAD_VS, wd, d);
  endtask

  task automatic rd45(input logic [4:0] pa, input logic [15:0] ad, output logic [15:0] rd);
    logic [15:0] d;
    frame(1'b0, `OP45_ADDR, pa, `DEVAD_VS, ad, d);
    frame(1'b0, 2'h3, pa, `DEVAD_VS, 16'h0000, rd);
  endtask

  // Read-modify-write so reserved bits keep what they hold
  task automatic set_pll(input logic [4:0] pa, input logic [3:0] code, input int vco_mhz);
    logic [15:0] v;
    rd45(pa, `REG_PLL, v);
    v[`F_FACT] = code;
    v[`B_VCO]  = (vco_mhz < 2500);  // Lower VCO band below 2.5 GHz
    wr45(pa, `REG_PLL, v);
  endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the channel serdes configuration bank
`timescale 1ns/1ps
`include "serdes_cfg_consts.svh"
module tb_top;
  import serdes_cfg_pkg::*;
  localparam logic [4:0] PORT    = 5'h03;
  localparam logic [4:0] RA_CTRL = 5'h01;
  localparam logic [4:0] RA_PLL  = 5'h02;
  typedef struct {logic [4:0] ra; logic [15:0] wd; logic [15:0] rd; logic [20:0] outs;} row_s;

  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        mode_strap_in = 1'b0;
  logic        clause45_strap_in = 1'b1;
  logic        autoneg_on_in = 1'b0;
  logic        autoneg_10g_in = 1'b0;
  logic        channel_sleep_pin_n_in = 1'b1;
  logic        mdc, host_drv, host_oe, mdio_out, mdio_oe_out, speed_10g_out;
  logic        hs_ref_sel_out, ls_ref_sel_out, hs_vco_low_band_out, hs_pll_enable_out;
  logic        hs_pll_factor_bad_out, datapath_sleep_out;
  logic [7:0]  hs_pll_factor_x4_out;
  lane_ratio_e rx_ratio_out, tx_ratio_out;
  pll_bw_e     hs_pll_bw_out;
  int          fail_count = 0;
  int          samples_checked = 0;
  row_s        rows[$];
  logic [15:0] got, w;
  logic [7:0]  x4 [16] = '{8'h00, 8'h00, 8'h10, 8'h14, 8'h18, 8'h20, 8'h21, 8'h28,
                          8'h30, 8'h32, 8'h3C, 8'h40, 8'h42, 8'h50, 8'h64, 8'h00};
  // Straps, control word, expected speed
  logic [20:0] mtab [6] = '{{4'b0110, 16'h0800, 1'b0}, {4'b0111, 16'h0000, 1'b1},
                           {4'b0000, 16'h0800, 1'b0}, {4'b0000, 16'h0400, 1'b1},
                           {4'b0110, 16'h0400, 1'b1}, {4'b1000, 16'h0000, 1'b1}};

  // Open line with pull-up: whoever enables drives, else it floats high
  wire logic        mdio_line = mdio_oe_out ? mdio_out : (host_oe ? host_drv : 1'b1);
  wire logic [20:0] obs = {speed_10g_out, rx_ratio_out, tx_ratio_out, hs_ref_sel_out,
                           ls_ref_sel_out, hs_pll_bw_out, hs_vco_low_band_out,
                           hs_pll_enable_out, hs_pll_factor_x4_out, hs_pll_factor_bad_out,
                           datapath_sleep_out};

  always #20 ref_clk_in = ~ref_clk_in;

  channel_serdes_config_regs channel_serdes_config_regs_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .mdc_in(mdc), .mdio_in(mdio_line),
    .port_addr_in(PORT), .mode_strap_in(mode_strap_in), .clause45_strap_in(clause45_strap_in),
    .autoneg_on_in(autoneg_on_in), .autoneg_10g_in(autoneg_10g_in),
    .channel_sleep_pin_n_in(channel_sleep_pin_n_in), .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out), .speed_10g_out(speed_10g_out), .rx_ratio_out(rx_ratio_out),
    .tx_ratio_out(tx_ratio_out), .hs_ref_sel_out(hs_ref_sel_out),
    .ls_ref_sel_out(ls_ref_sel_out), .hs_pll_bw_out(hs_pll_bw_out),
    .hs_vco_low_band_out(hs_vco_low_band_out), .hs_pll_enable_out(hs_pll_enable_out),
    .hs_pll_factor_x4_out(hs_pll_factor_x4_out),
    .hs_pll_factor_bad_out(hs_pll_factor_bad_out), .datapath_sleep_out(datapath_sleep_out));

  mdio_host_model mdio_host_model_inst (
    .clk_in(ref_clk_in), .mdio_line_in(mdio_line), .mdc_out(mdc),
    .mdio_drv_out(host_drv), .mdio_oe_out(host_oe));

  // Compare helpers, one per kind of result; every mismatch goes through miss
  task automatic miss(input string m);
    fail_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
      miss($sformatf("register %h, wanted %h", g, e));
  endtask
  task automatic chk_out(input logic [20:0] g, input logic [20:0] e);
    samples_checked++;
    if (g !== e)
      miss($sformatf("outputs %h, wanted %h", g, e));
  endtask
  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
      miss($sformatf("flag %b, wanted %b", g, e));
  endtask

  // Frame helpers; on reads whatever the line carried lands in got, writes leave it zero
  task automatic fr(input logic c22, input logic [1:0] op, input logic [4:0] pa, ra,
                    input logic [15:0] wd);
    mdio_host_model_inst.frame(c22, op, pa, ra, wd, got);
  endtask
  task automatic w22(input logic [4:0] ra, input logic [15:0] wd);
    fr(1'b1, `OP22_WR, PORT, ra, wd);
  endtask
  task automatic r22(input logic [4:0] ra);
    fr(1'b1, `OP22_RD, PORT, ra, 16'h0000);
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [20:0] pk(logic sp, logic [1:0] rx, logic [1:0] tx, logic hs,
                                     logic ls, logic [1:0] bw, logic vco, logic en,
                                     logic [7:0] fx, logic bad, logic slp);
    return {sp, rx, tx, hs, ls, bw, vco, en, fx, bad, slp};
  endfunction
  // Control rows keep the PLL setup at reset; unwritable bits read back zero
  function automatic void add_ctrl(logic [15:0] wd, logic sp, logic [1:0] rx, logic [1:0] tx,
                                   logic hs, logic ls, logic slp);
    rows.push_back('{RA_CTRL, wd, wd & `CTRL_WMASK, pk(sp, rx, tx, hs, ls, 2'h3, 1'b0, !slp,
                                                      8'h50, 1'b0, slp)});
  endfunction

  // Watchdog: the tests need about 43k clocks
  initial
  begin
    #3_000_000;
    miss("watchdog expired");
    final_report();
  end

  // Reset, row table, then awkward cases
  initial
  begin
    add_ctrl(16'h0000, 1'b0, RATIO_1, RATIO_1, 1'b0, 1'b0, 1'b0);
    add_ctrl(16'h0800, 1'b1, RATIO_2, RATIO_2, 1'b0, 1'b0, 1'b0);
    add_ctrl(16'h0400, 1'b1, RATIO_2, RATIO_2, 1'b0, 1'b0, 1'b0);
    add_ctrl(16'h2B00, 1'b1, RATIO_1, RATIO_4, 1'b0, 1'b0, 1'b0);
    add_ctrl(16'h1B00, 1'b1, RATIO_4, RATIO_1, 1'b0, 1'b0, 1'b0);
    add_ctrl(16'h0B02, 1'b1, RATIO_4, RATIO_4, 1'b1, 1'b1, 1'b0);
    add_ctrl(16'h0B03, 1'b1, RATIO_4, RATIO_4, 1'b1, 1'b0, 1'b0);
    add_ctrl(16'h0B01, 1'b1, RATIO_4, RATIO_4, 1'b0, 1'b1, 1'b0);
    add_ctrl(16'h8B00, 1'b1, RATIO_4, RATIO_4, 1'b0, 1'b0, 1'b1);
    add_ctrl(16'h0BFC, 1'b1, RATIO_4, RATIO_4, 1'b0, 1'b0, 1'b0);
    rows.push_back('{RA_PLL, 16'h830D, 16'h830D, pk(1'b1, RATIO_4, RATIO_4, 1'b0, 1'b0, 2'h3,
                                                    1'b0, 1'b0, 8'h50, 1'b0, 1'b0)});
    for (int c = 0; c < 16; c++)
    begin
      w = {6'h20, c[1:0], 1'b0, c[0], 1'b0, 1'b1, c[3:0]};
      rows.push_back('{RA_PLL, w, w, pk(1'b1, RATIO_4, RATIO_4, 1'b0, 1'b0, c[1:0], c[0], 1'b1,
                                        x4[c], x4[c] == 8'h00, 1'b0)});
    end
    repeat (6) @(negedge ref_clk_in);
    chk_bit(datapath_sleep_out, 1'b1);
    chk_bit(mdio_oe_out, 1'b0);
    repeat (6) @(negedge ref_clk_in);
    reset_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk_out(obs, pk(1'b1, RATIO_4, RATIO_4, 1'b0, 1'b0, 2'h3, 1'b0, 1'b1, 8'h50, 1'b0, 1'b0));
    mdio_host_model_inst.rd45(PORT, `REG_CTRL, got);
    chk_reg(got, `CTRL_RESET);
    mdio_host_model_inst.rd45(PORT, `REG_PLL, got);
    chk_reg(got, `PLL_RESET);
    foreach (rows[i])
    begin
      w22(rows[i].ra, rows[i].wd);
      r22(rows[i].ra);
      chk_reg(got, rows[i].rd);
      chk_out(obs, rows[i].outs);
    end
    // Wrong port, wrong device and unmapped register are all ignored
    fr(1'b1, `OP22_WR, PORT ^ 5'h01, RA_CTRL, 16'h0000);
    fr(1'b1, `OP22_RD, PORT ^ 5'h01, RA_CTRL, 16'h0000);
    chk_reg(got, 16'hFFFF);
    fr(1'b0, `OP45_ADDR, PORT, 5'h1D, `REG_CTRL);
    fr(1'b0, `OP45_WR, PORT, 5'h1D, 16'h0000);
    w22(5'h05, 16'h0000);
    r22(5'h05);
    chk_reg(got, 16'h0000);
    // Post-read increment walks from control to PLL setup
    fr(1'b0, `OP45_ADDR, PORT, `DEVAD_VS, `REG_CTRL);
    fr(1'b0, `OP45_RDINC, PORT, `DEVAD_VS, 16'h0000);
    chk_reg(got, `CTRL_RESET);
    fr(1'b0, 2'h3, PORT, `DEVAD_VS, 16'h0000);
    chk_reg(got, 16'h835F);
    foreach (mtab[i])
    begin
      @(negedge ref_clk_in);
      {mode_strap_in, clause45_strap_in, autoneg_on_in, autoneg_10g_in} = mtab[i][20:17];
      w22(RA_CTRL, mtab[i][16:1]);
      repeat (8) @(negedge ref_clk_in);
      chk_bit(speed_10g_out, mtab[i][0]);
    end
    // Sleep pin gates the PLL and the data path
    {mode_strap_in, clause45_strap_in, autoneg_on_in, autoneg_10g_in} = 4'b0100;
    w22(RA_CTRL, `CTRL_RESET);
    channel_sleep_pin_n_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk_bit(hs_pll_enable_out, 1'b0);
    chk_bit(datapath_sleep_out, 1'b1);
    channel_sleep_pin_n_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    chk_bit(hs_pll_enable_out, 1'b1);
    chk_bit(datapath_sleep_out, 1'b0);
    mdio_host_model_inst.set_pll(PORT, 4'hD, 3125);
    repeat (8) @(negedge ref_clk_in);
    chk_bit(hs_vco_low_band_out, 1'b0);
    mdio_host_model_inst.set_pll(PORT, 4'h2, 625);
    repeat (8) @(negedge ref_clk_in);
    chk_bit(hs_vco_low_band_out, 1'b1);
    chk_bit(hs_pll_factor_x4_out == 8'h10, 1'b1);
    // Second reset in mid-run restores the defaults
    reset_in = 1'b1;
    repeat (12) @(negedge ref_clk_in);
    reset_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    r22(RA_PLL);
    chk_reg(got, `PLL_RESET);
    chk_bit(mdio_oe_out, 1'b0);
    final_report();
  end
endmodule
